// [src/bod_pkg.sv]
package bod_pkg;
    localparam int WORD_W = 14;
    localparam int REG_IDX_W = 7;
    localparam int REG_IDX_LSB = 0;
    localparam int TARGET_BIT = 7;
    localparam int POS_LSB = 7;
    localparam int POS_W = 3;
    localparam int BIT_OP_LSB = 10;
    localparam int BYTE_OP_LSB = 8;
    localparam int GROUP_LSB = 12;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int PHASES = 4;
    localparam int OSC_MHZ = 200;
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_JUMP = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;
    localparam logic [3:0] OP_MISC = 4'h0;
    localparam logic [3:0] OP_CLR = 4'h1;
    localparam logic [3:0] OP_DEC = 4'h3;
    localparam logic [3:0] OP_IOR = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_ADD = 4'h7;
    localparam logic [3:0] OP_MOV = 4'h8;
    localparam logic [3:0] OP_COM = 4'h9;
    localparam logic [3:0] OP_INC = 4'hA;
    localparam logic [3:0] OP_DECSZ = 4'hB;
    localparam logic [3:0] OP_INCSZ = 4'hF;
    localparam logic [1:0] BIT_OP_TSC = 2'h2;
    localparam logic [1:0] BIT_OP_TSS = 2'h3;
    localparam logic [7:0] REG_ONE = 8'h01;
    typedef enum {
        BOD_NOP, BOD_ADD, BOD_AND, BOD_IOR, BOD_COM, BOD_DEC, BOD_DECSZ, BOD_INC, BOD_INCSZ,
        BOD_MOV, BOD_ZERO_REGISTER_OP, BOD_ZERO_ACCUMULATOR_OP, BOD_STORE, BOD_BITOP, BOD_JUMP, BOD_LIT, BOD_OTHER
    } bod_op_t;
endpackage

// [src/bod_phase_gen.sv]
`timescale 1ns/1ps
module bod_phase_gen #(
    parameter int PHASES = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    output logic [1:0] phase,
    output logic cycle_start
);
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            phase <= 2'h0;
        end else if (phase == 2'(PHASES - 1)) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    assign cycle_start = (phase == 2'h0);
endmodule

// [src/bod_field_split.sv]
`timescale 1ns/1ps
module bod_field_split (
    input wire logic [13:0] word,
    output logic [6:0] reg_index,
    output logic target_sel,
    output logic [2:0] position_select,
    output logic [7:0] literal8,
    output logic [10:0] literal11
);
    import bod_pkg::*;

    assign reg_index = word[REG_IDX_LSB +: REG_IDX_W];
    assign target_sel = word[TARGET_BIT];
    assign position_select = word[POS_LSB +: POS_W];
    assign literal8 = word[0 +: LIT8_W];
    assign literal11 = word[0 +: LIT11_W];
endmodule

// [src/bod_decoder.sv]
`timescale 1ns/1ps
// Function
// - Bits 6..0 give the 7-bit register index 0x00 to 0x7F.
// - Bit 7 zero targets the accumulator, one targets the register.
// - Bit operations select one bit of eight and touch only it.
// - Don't-care bits never change the decoded result.
// - Every instruction takes one cycle unless skip or jump applies.
// - Taken skip or program counter change takes two cycles, second a no-op.
// - One instruction cycle is four oscillator periods.
// - Codes 0111 add, 0101 and, 0100 or with their flags, one cycle.
// - 0011 decrements with zero flag; 1011 decrements, skips on zero.
// - 1010 increments with zero flag; 1111 increments, skips on zero.
// - Group 00 is byte ops; 1001 complements, 1000 moves, both zero flag.
module bod_decoder (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [13:0] instr_word,
    input wire logic instr_valid,
    input wire logic skip_cond,
    output logic cycle_start,
    output logic [6:0] reg_index,
    output logic result_to_register,
    output logic [2:0] position_select,
    output logic [7:0] bit_mask,
    output logic [7:0] literal8,
    output logic [10:0] literal11,
    output bod_pkg::bod_op_t op_kind,
    output logic affects_carry,
    output logic affects_digit_carry,
    output logic affects_zero,
    output logic two_cycle,
    output logic forced_nop,
    output logic decode_valid
);
    import bod_pkg::*;

    logic cyc_edge;
    logic [6:0] idx_w;
    logic tgt_w;
    logic [2:0] pos_w;
    logic [7:0] lit8_w;
    logic [10:0] lit11_w;
    bod_op_t kind_nxt;
    logic c_nxt, dc_nxt, z_nxt, tgt_nxt, branch_nxt, skippy_nxt;
    logic pending_nop_r;

    function automatic logic [7:0] bit_select(input logic [2:0] pos);
        bit_select = REG_ONE << pos;
    endfunction

    // Taken skip or any branch needs the extra no-op cycle.
    function automatic logic takes_two(input logic valid, input logic branch, input logic skippy, input logic skip);
        takes_two = valid && (branch || (skippy && skip));
    endfunction

    bod_phase_gen #(.PHASES(PHASES)) u_phase (
        .core_clk(core_clk),
        .nrst(nrst),
        .phase(),
        .cycle_start(cyc_edge)
    );

    bod_field_split u_fields (
        .word(instr_word),
        .reg_index(idx_w),
        .target_sel(tgt_w),
        .position_select(pos_w),
        .literal8(lit8_w),
        .literal11(lit11_w)
    );

    always_comb begin
        kind_nxt = BOD_OTHER;
        c_nxt = 1'b0;
        dc_nxt = 1'b0;
        z_nxt = 1'b0;
        tgt_nxt = tgt_w;
        branch_nxt = 1'b0;
        skippy_nxt = 1'b0;
        case (instr_word[GROUP_LSB +: 2])
            GRP_BYTE: begin
                case (instr_word[BYTE_OP_LSB +: 4])
                    OP_ADD: begin
                        kind_nxt = BOD_ADD;
                        c_nxt = 1'b1;
                        dc_nxt = 1'b1;
                        z_nxt = 1'b1;
                    end
                    OP_AND: begin
                        kind_nxt = BOD_AND;
                        z_nxt = 1'b1;
                    end
                    OP_IOR: begin
                        kind_nxt = BOD_IOR;
                        z_nxt = 1'b1;
                    end
                    OP_DEC: begin
                        kind_nxt = BOD_DEC;
                        z_nxt = 1'b1;
                    end
                    OP_DECSZ: begin
                        kind_nxt = BOD_DECSZ;
                        skippy_nxt = 1'b1;
                    end
                    OP_INC: begin
                        kind_nxt = BOD_INC;
                        z_nxt = 1'b1;
                    end
                    OP_INCSZ: begin
                        kind_nxt = BOD_INCSZ;
                        skippy_nxt = 1'b1;
                    end
                    OP_COM: begin
                        kind_nxt = BOD_COM;
                        z_nxt = 1'b1;
                    end
                    OP_MOV: begin
                        kind_nxt = BOD_MOV;
                        z_nxt = 1'b1;
                    end
                    // Clear forms; low bits ignored for the accumulator.
                    OP_CLR: begin
                        kind_nxt = tgt_w ? BOD_ZERO_REGISTER_OP : BOD_ZERO_ACCUMULATOR_OP;
                        z_nxt = 1'b1;
                    end
                    OP_MISC: begin
                        if (tgt_w) begin
                            kind_nxt = BOD_STORE;
                        end else if (instr_word[4:0] == 5'h00) begin
                            kind_nxt = BOD_NOP;
                            tgt_nxt = 1'b0;
                        end
                    end
                    default: begin
                        kind_nxt = BOD_OTHER;
                    end
                endcase
            end
            GRP_BIT: begin
                kind_nxt = BOD_BITOP;
                tgt_nxt = 1'b1;
                skippy_nxt = (instr_word[BIT_OP_LSB +: 2] == BIT_OP_TSC) ||
                             (instr_word[BIT_OP_LSB +: 2] == BIT_OP_TSS);
            end
            // Jumps always change the program counter.
            GRP_JUMP: begin
                kind_nxt = BOD_JUMP;
                tgt_nxt = 1'b0;
                branch_nxt = 1'b1;
            end
            GRP_LIT: begin
                kind_nxt = BOD_LIT;
                tgt_nxt = 1'b0;
            end
            default: begin
                kind_nxt = BOD_OTHER;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cycle_start <= 1'b0;
        end else begin
            cycle_start <= cyc_edge;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_index <= 7'h00;
            position_select <= 3'h0;
            bit_mask <= 8'h00;
            literal8 <= 8'h00;
            literal11 <= 11'h000;
        end else if (cyc_edge && instr_valid && !pending_nop_r) begin
            reg_index <= idx_w;
            position_select <= pos_w;
            bit_mask <= bit_select(pos_w);
            literal8 <= lit8_w;
            literal11 <= lit11_w;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            op_kind <= BOD_NOP;
            result_to_register <= 1'b0;
            affects_carry <= 1'b0;
            affects_digit_carry <= 1'b0;
            affects_zero <= 1'b0;
            decode_valid <= 1'b0;
        end else if (cyc_edge) begin
            decode_valid <= instr_valid && !pending_nop_r;
            if (instr_valid && !pending_nop_r) begin
                op_kind <= kind_nxt;
                result_to_register <= tgt_nxt;
                affects_carry <= c_nxt;
                affects_digit_carry <= dc_nxt;
                affects_zero <= z_nxt;
            end else begin
                op_kind <= BOD_NOP;
                result_to_register <= 1'b0;
                affects_carry <= 1'b0;
                affects_digit_carry <= 1'b0;
                affects_zero <= 1'b0;
            end
        end
    end

    // Single cycle by default; taken skip or branch adds a no-op cycle.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pending_nop_r <= 1'b0;
            two_cycle <= 1'b0;
            forced_nop <= 1'b0;
        end else if (cyc_edge) begin
            forced_nop <= pending_nop_r;
            if (pending_nop_r) begin
                pending_nop_r <= 1'b0;
                two_cycle <= 1'b0;
            end else begin
                pending_nop_r <= takes_two(instr_valid, branch_nxt, skippy_nxt, skip_cond);
                two_cycle <= takes_two(instr_valid, branch_nxt, skippy_nxt, skip_cond);
            end
        end
    end
endmodule

// [verif/bod_decoder_chk.sv]
`timescale 1ns/1ps
module bod_decoder_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [13:0] instr_word,
    input wire logic instr_valid,
    input wire logic skip_cond,
    input wire logic cycle_start,
    input wire logic [6:0] reg_index,
    input wire logic result_to_register,
    input wire logic [2:0] position_select,
    input wire logic [7:0] bit_mask,
    input wire logic [7:0] literal8,
    input wire logic [10:0] literal11,
    input bod_pkg::bod_op_t op_kind,
    input wire logic affects_carry,
    input wire logic affects_digit_carry,
    input wire logic affects_zero,
    input wire logic two_cycle,
    input wire logic forced_nop,
    input wire logic decode_valid
);
    import bod_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    cycle_len_a: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
        else $error("bad cycle length");
    index_field_a: assert property (cycle_start && decode_valid && $past(instr_word[13]) == 1'b0
        |-> reg_index == $past(instr_word[6:0])) else $error("bad register index");
    target_sel_a: assert property (cycle_start && decode_valid && $past(instr_word[13:12]) == GRP_BYTE
        |-> result_to_register == $past(instr_word[7])) else $error("bad target select");
    bit_pos_a: assert property (cycle_start && decode_valid && $past(instr_word[13:12]) == GRP_BIT
        |-> position_select == $past(instr_word[9:7]) && bit_mask == 8'h01 << position_select)
        else $error("bad bit position");
    one_cycle_a: assert property (cycle_start && decode_valid && !$past(skip_cond) && op_kind != BOD_OTHER
        && $past(instr_word[13:12]) == GRP_BYTE |-> !two_cycle) else $error("byte op not single cycle");
    nop_second_a: assert property (cycle_start && two_cycle
        |-> ##4 (cycle_start && forced_nop && !decode_valid && op_kind == BOD_NOP)) else $error("no forced nop");
    add_flags_a: assert property (cycle_start && op_kind == BOD_ADD
        |-> affects_carry && affects_digit_carry && affects_zero) else $error("bad add flags");
    skip_flags_a: assert property (cycle_start && op_kind inside {BOD_DECSZ, BOD_INCSZ}
        |-> !affects_zero && two_cycle == $past(skip_cond)) else $error("bad skip decode");
    zero_only_a: assert property (cycle_start && op_kind inside {BOD_COM, BOD_MOV, BOD_AND, BOD_IOR}
        |-> affects_zero && !affects_carry) else $error("bad zero flag");
    jump_lit_a: assert property (cycle_start && op_kind == BOD_JUMP
        |-> two_cycle && literal11 == $past(instr_word[10:0])) else $error("bad jump decode");
endmodule
bind bod_decoder bod_decoder_chk u_chk (.core_clk(core_clk), .nrst(nrst), .instr_word(instr_word),
    .instr_valid(instr_valid), .skip_cond(skip_cond), .cycle_start(cycle_start), .reg_index(reg_index),
    .result_to_register(result_to_register), .position_select(position_select), .bit_mask(bit_mask),
    .literal8(literal8), .literal11(literal11), .op_kind(op_kind), .affects_carry(affects_carry),
    .affects_digit_carry(affects_digit_carry), .affects_zero(affects_zero), .two_cycle(two_cycle),
    .forced_nop(forced_nop), .decode_valid(decode_valid));

// [verif/bod_fetch_model.sv]
`timescale 1ns/1ps
module bod_fetch_model (
    output logic [13:0] instr_word,
    output logic instr_valid,
    output logic skip_cond
);
    initial begin
        instr_word = 14'h0000;
        instr_valid = 1'b0;
        skip_cond = 1'b0;
    end
    // An idle fetch bus shows the inverse of the last word, never a stale copy.
    task automatic present(input logic [13:0] word, input logic valid, input logic skip);
        instr_word = valid ? word : ~instr_word;
        instr_valid = valid;
        skip_cond = skip;
    endtask
endmodule

// [verif/byte_op_instruction_decoder_test.sv]
`timescale 1ns/1ps
module byte_op_instruction_decoder_test;
    import bod_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [13:0] instr_word;
    logic instr_valid, skip_cond, cycle_start, result_to_register, two_cycle, forced_nop, decode_valid;
    logic affects_carry, affects_digit_carry, affects_zero;
    logic [6:0] reg_index;
    logic [2:0] position_select;
    logic [7:0] bit_mask, literal8;
    logic [10:0] literal11;
    bod_op_t op_kind;
    int err_total = 0;
    int checks_done = 0;
    int gap;
    always #2.5 core_clk = ~core_clk;
    bod_fetch_model fetch (.instr_word(instr_word), .instr_valid(instr_valid), .skip_cond(skip_cond));
    bod_decoder dut (.core_clk(core_clk), .nrst(nrst), .instr_word(instr_word), .instr_valid(instr_valid),
        .skip_cond(skip_cond), .cycle_start(cycle_start), .reg_index(reg_index), .literal8(literal8),
        .result_to_register(result_to_register), .position_select(position_select), .bit_mask(bit_mask),
        .literal11(literal11), .op_kind(op_kind), .affects_carry(affects_carry), .two_cycle(two_cycle),
        .affects_digit_carry(affects_digit_carry), .affects_zero(affects_zero), .forced_nop(forced_nop),
        .decode_valid(decode_valid));
    task automatic final_report;
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Presents a word and returns at the next cycle start; after a taken skip or branch that cycle shows the forced no-op.
    task automatic issue(input logic [13:0] word, input logic valid, input logic skip);
        fetch.present(word, valid, skip);
        gap = 0;
        do begin
            @(negedge core_clk);
            gap++;
        end while (cycle_start !== 1'b1 && gap < 9);
        if (cycle_start !== 1'b1) begin
            err_total++;
            final_report();
        end
    endtask
    task automatic t_misc;
        logic [13:0] words [6] = '{14'h0000, 14'h0060, 14'h00A5, 14'h01A5, 14'h0100, 14'h017F};
        bod_op_t kinds [6] = '{BOD_NOP, BOD_NOP, BOD_STORE, BOD_ZERO_REGISTER_OP, BOD_ZERO_ACCUMULATOR_OP, BOD_ZERO_ACCUMULATOR_OP};
        for (int i = 0; i < 6; i++) begin
            issue(words[i], 1'b1, 1'b0);
            chk(op_kind, kinds[i]);
            chk({affects_zero, decode_valid}, {i > 2, 1'b1});
        end
        issue(14'h0705, 1'b0, 1'b0);
        chk({op_kind == BOD_NOP, decode_valid}, 2'h2);
    endtask
    task automatic t_byte;
        logic [3:0] ops [9] = '{OP_ADD, OP_AND, OP_IOR, OP_DEC, OP_DECSZ, OP_INC, OP_INCSZ, OP_COM, OP_MOV};
        bod_op_t kinds [9] = '{BOD_ADD, BOD_AND, BOD_IOR, BOD_DEC, BOD_DECSZ, BOD_INC, BOD_INCSZ, BOD_COM, BOD_MOV};
        logic [2:0] flags [9] = '{3'h7, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1, 3'h0, 3'h1, 3'h1};
        for (int i = 0; i < 9; i++) begin
            issue({2'h0, ops[i], i[0], i[0] ? 7'h7F : 7'h00}, 1'b1, 1'b0);
            chk(gap, PHASES);
            chk(op_kind, kinds[i]);
            chk({affects_carry, affects_digit_carry, affects_zero}, flags[i]);
            chk({result_to_register, reg_index, two_cycle}, {i[0], i[0] ? 7'h7F : 7'h00, 1'b0});
        end
    endtask
    task automatic t_skip;
        issue(14'h0B05, 1'b1, 1'b0);
        chk(two_cycle, 1'b0);
        issue(14'h0F05, 1'b1, 1'b1);
        chk(two_cycle, 1'b1);
        issue(14'h0705, 1'b1, 1'b0);
        chk({forced_nop, decode_valid, op_kind == BOD_NOP}, 3'h5);
        issue(14'h0705, 1'b1, 1'b0);
        chk({forced_nop, op_kind == BOD_ADD}, 2'h1);
    endtask
    task automatic t_bit;
        issue(14'h1FAA, 1'b1, 1'b1);
        chk({position_select, bit_mask, reg_index, two_cycle}, {3'h7, 8'h80, 7'h2A, 1'b1});
        chk(op_kind, BOD_BITOP);
        issue(14'h1001, 1'b1, 1'b0);
        issue(14'h1001, 1'b1, 1'b0);
        chk({position_select, bit_mask, reg_index, two_cycle}, {3'h0, 8'h01, 7'h01, 1'b0});
        issue(14'h1405, 1'b1, 1'b1);
        chk(two_cycle, 1'b0);
        issue(14'h1A05, 1'b1, 1'b1);
        chk({op_kind == BOD_BITOP, two_cycle}, 2'h3);
        issue(14'h0000, 1'b1, 1'b0);
        chk({forced_nop, decode_valid}, 2'h2);
    endtask
    task automatic t_jump;
        issue(14'h2DA5, 1'b1, 1'b0);
        chk({op_kind == BOD_JUMP, two_cycle, literal11}, {2'h3, 11'h5A5});
        issue(14'h33C3, 1'b1, 1'b0);
        issue(14'h33C3, 1'b1, 1'b0);
        chk({op_kind == BOD_LIT, two_cycle, literal8}, {2'h2, 8'hC3});
        issue(14'h30C3, 1'b1, 1'b0);
        chk({op_kind == BOD_LIT, literal8}, {1'b1, 8'hC3});
    endtask
    // Resets in the middle of a branch and expects a clean first decode.
    task automatic t_reset;
        issue(14'h2DA5, 1'b1, 1'b0);
        nrst = 1'b0;
        @(negedge core_clk);
        chk({cycle_start, decode_valid, two_cycle, forced_nop, op_kind == BOD_NOP}, 5'h01);
        nrst = 1'b1;
        issue(14'h0705, 1'b1, 1'b0);
        chk({gap[3:0], op_kind == BOD_ADD, forced_nop}, {4'h1, 2'h2});
    endtask
    initial begin
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        t_misc();
        t_byte();
        t_skip();
        t_bit();
        t_jump();
        t_reset();
        final_report();
    end
endmodule
